// ==== hw/pmrs_top.sv ====
// module: pointer decode, common status, test register and per-port timers
`timescale 1ns/1ps
`default_nettype none
module pmrs_top #(
  parameter int ERR_DELAY_CYCLES = pmrs_pkg::ERR_DELAY_CYC,
  parameter int DISC_PHASE_CYCLES = pmrs_pkg::DISC_PHASE_CYC,
  parameter int DISCONNECT_CYCLES = pmrs_pkg::DISCONNECT_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic PTR_WR_IN,
  input wire logic [7:0] PTR_BYTE_IN,
  output logic ACK_OUT,
  input wire logic DATA_WR_IN,
  input wire logic [7:0] WR_BYTE_IN,
  input wire logic DATA_RD_IN,
  output logic [7:0] RD_BYTE_OUT,
  output pmrs_pkg::pmrs_ptr_t PTR_OUT,
  input wire logic [7:0] PORT_RD_BYTE_IN,
  output logic PORT_WR_OUT,
  output pmrs_pkg::pmrs_wr_t PORT_WR_BUS_OUT,
  output logic [3:0] DISABLE_CALL_OUT,
  input wire logic AUTOMATIC_MODE_IN,
  input wire logic [3:0] FAULT_EVENT_IN,
  input wire logic [1:0] CHIP_REV_IN,
  input wire logic [1:0] CHIP_ID_IN,
  output logic THERMAL_SHUTDOWN_FORCE_OUT,
  output logic POR_HOLD_OUT,
  output logic DISC_HALT_OUT,
  output logic DISC_TIMERS_OFF_OUT,
  output logic ERROR_DELAY_TIMER_OFF_OUT,
  input wire logic [3:0] DISC_START_IN,
  output logic [3:0] DISC_DONE_OUT,
  input wire logic [3:0] LOW_CURRENT_IN,
  output logic [3:0] DISCONNECT_OUT
);

  localparam logic [pmrs_pkg::TMR_W-1:0] ERR_LOAD = pmrs_pkg::TMR_W'(ERR_DELAY_CYCLES - 1);
  localparam logic [pmrs_pkg::TMR_W-1:0] DISC_LOAD = pmrs_pkg::TMR_W'(DISC_PHASE_CYCLES - 1);
  localparam logic [pmrs_pkg::TMR_W-1:0] DCD_LOAD = pmrs_pkg::TMR_W'(DISCONNECT_CYCLES - 1);
  localparam logic [pmrs_pkg::TMR_W-1:0] ZERO_LOAD = '0;

  typedef struct packed {
    pmrs_pkg::pmrs_ptr_t ptr;
    logic [7:0] test;
    logic [7:0] rd_data;
    logic ack;
    logic wr_stb;
    pmrs_pkg::pmrs_wr_t wr;
    logic [3:0] disable_call;
    logic [3:0] low_cur_q;
  } pmrs_st_t;

  pmrs_st_t st_q;
  pmrs_st_t st_d;

  logic [3:0] fault_flag;
  logic [3:0] err_done;
  logic [3:0] err_start;
  logic [3:0] flag_clear;
  logic [3:0] dcd_start;
  logic [3:0] dcd_abort;
  logic err_off;
  logic disc_off;
  logic disc_halt;
  logic dcd_now;

  // common codes ignore the port field, except that a common-control write still forwards it to the port logic
  function automatic logic is_common(input logic [3:0] sel);
    is_common = (sel == pmrs_pkg::SEL_COMMON_READ) || (sel == pmrs_pkg::SEL_COMMON_CTRL) ||
                (sel == pmrs_pkg::SEL_TEST);
  endfunction : is_common

  // codes whose data live in the per-port control, status and converter logic
  function automatic logic is_port_reg(input logic [3:0] sel);
    is_port_reg = (sel >= pmrs_pkg::SEL_PORT_CTRL1) && (sel <= pmrs_pkg::SEL_TEMP_HI);
  endfunction : is_port_reg

  function automatic logic [7:0] read_mux(
    input logic [3:0] sel,
    input logic [3:0] flags,
    input logic [1:0] rev,
    input logic [1:0] id,
    input logic [7:0] port_byte
  );
    logic [7:0] r;
    r = 8'h00;
    case (sel)
      pmrs_pkg::SEL_COMMON_READ: begin
        r = {flags, rev, id};
      end
      pmrs_pkg::SEL_NOP: begin
        r = 8'h00;
      end
      pmrs_pkg::SEL_TEST: begin
        r = 8'h00;
      end
      pmrs_pkg::SEL_COMMON_CTRL: begin
        r = 8'h00;
      end
      default: begin
        // control, status and the split converter results of the addressed port
        if (is_port_reg(sel)) begin
          r = port_byte;
        end
      end
    endcase
    read_mux = r;
  endfunction : read_mux

  assign err_off = st_q.test[pmrs_pkg::TEST_ERRDLY_BIT];
  assign disc_off = st_q.test[pmrs_pkg::TEST_DISC_TMR_BIT];
  assign disc_halt = st_q.test[pmrs_pkg::TEST_DISC_HALT_BIT];
  assign dcd_now = st_q.test[pmrs_pkg::TEST_DCDISC_BIT];

  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    st_d.wr_stb = 1'b0;
    st_d.disable_call = 4'h0;
    st_d.low_cur_q = LOW_CURRENT_IN;
    // pointer taken whole; unused bits forced to zero
    if (PTR_WR_IN) begin
      st_d.ptr = pmrs_pkg::pmrs_ptr_t'(PTR_BYTE_IN);
      st_d.ptr.spare_hi = 1'b0;
      st_d.ptr.spare_lo = 1'b0;
      st_d.ack = 1'b1;
    end else if (DATA_WR_IN) begin
      case (st_q.ptr.sel)
        pmrs_pkg::SEL_TEST: begin
          st_d.test = WR_BYTE_IN & pmrs_pkg::TEST_USED_MASK;
        end
        pmrs_pkg::SEL_NOP: begin
          st_d.test = st_q.test;
        end
        pmrs_pkg::SEL_COMMON_READ: begin
          st_d.test = st_q.test;
        end
        default: begin
          // per-port and common-control writes go to the port logic
          st_d.wr_stb = 1'b1;
          st_d.wr.sel = st_q.ptr.sel;
          st_d.wr.port = st_q.ptr.port;
          st_d.wr.data = WR_BYTE_IN;
          if (st_q.ptr.sel == pmrs_pkg::SEL_PORT_CTRL1 &&
              WR_BYTE_IN[3:0] == pmrs_pkg::FUNC_DISABLE) begin
            st_d.disable_call[st_q.ptr.port] = 1'b1;
          end
        end
      endcase
    end
    if (DATA_RD_IN) begin
      st_d.rd_data = read_mux(st_q.ptr.sel, fault_flag, CHIP_REV_IN, CHIP_ID_IN,
                              PORT_RD_BYTE_IN);
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_q <= '0;
      st_q.ptr <= pmrs_pkg::pmrs_ptr_t'(pmrs_pkg::PTR_RESET);
      st_q.test <= pmrs_pkg::TEST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // flag clearing depends on the operating mode
  always_comb begin
    for (int i = 0; i < pmrs_pkg::NUM_PORTS; i++) begin
      if (AUTOMATIC_MODE_IN) begin
        flag_clear[i] = err_done[i];
        err_start[i] = FAULT_EVENT_IN[i];
      end else begin
        flag_clear[i] = st_q.disable_call[i];
        err_start[i] = 1'b0;
      end
      dcd_start[i] = LOW_CURRENT_IN[i] && !st_q.low_cur_q[i];
      dcd_abort[i] = !LOW_CURRENT_IN[i];
    end
  end

  for (genvar p = 0; p < pmrs_pkg::NUM_PORTS; p++) begin : g_port
    pmrs_fault_flag u_flag (
      .clk_in(CLK_SYS_IN),
      .arst_n_in(ARST_N_IN),
      .set_in(FAULT_EVENT_IN[p]),
      .clear_in(flag_clear[p]),
      .flag_out(fault_flag[p])
    );

    // disabled timer never expires, so in automatic mode the flag stays up
    pmrs_timer u_err (
      .clk_in(CLK_SYS_IN),
      .arst_n_in(ARST_N_IN),
      .start_in(err_start[p]),
      .abort_in(err_off || !AUTOMATIC_MODE_IN),
      .hold_in(1'b0),
      .load_in(ERR_LOAD),
      .done_out(err_done[p])
    );

    pmrs_timer u_disc (
      .clk_in(CLK_SYS_IN),
      .arst_n_in(ARST_N_IN),
      .start_in(DISC_START_IN[p]),
      .abort_in(disc_off),
      .hold_in(disc_halt),
      .load_in(DISC_LOAD),
      .done_out(DISC_DONE_OUT[p])
    );

    // uses the short end of the allowed window
    pmrs_timer u_dcd (
      .clk_in(CLK_SYS_IN),
      .arst_n_in(ARST_N_IN),
      .start_in(dcd_start[p]),
      .abort_in(dcd_abort[p]),
      .hold_in(1'b0),
      .load_in(dcd_now ? ZERO_LOAD : DCD_LOAD),
      .done_out(DISCONNECT_OUT[p])
    );
  end

  assign ACK_OUT = st_q.ack;
  assign RD_BYTE_OUT = st_q.rd_data;
  assign PTR_OUT = st_q.ptr;
  assign PORT_WR_OUT = st_q.wr_stb;
  assign PORT_WR_BUS_OUT = st_q.wr;
  assign DISABLE_CALL_OUT = st_q.disable_call;
  assign THERMAL_SHUTDOWN_FORCE_OUT = st_q.test[pmrs_pkg::TEST_TSD_BIT];
  assign POR_HOLD_OUT = st_q.test[pmrs_pkg::TEST_POR_BIT];
  assign DISC_HALT_OUT = disc_halt;
  assign DISC_TIMERS_OFF_OUT = disc_off;
  assign ERROR_DELAY_TIMER_OFF_OUT = err_off;

endmodule : pmrs_top
`default_nettype wire

// ==== hw/pmrs_pkg.sv ====
// package: constants and carriers for the register-select and test block
package pmrs_pkg;

  localparam logic [3:0] SEL_COMMON_READ = 4'h0;
  localparam logic [3:0] SEL_COMMON_CTRL = 4'h1;
  localparam logic [3:0] SEL_PORT_CTRL1 = 4'h2;
  localparam logic [3:0] SEL_PORT_CTRL2 = 4'h3;
  localparam logic [3:0] SEL_PORT_STAT1 = 4'h4;
  localparam logic [3:0] SEL_PORT_STAT2 = 4'h5;
  localparam logic [3:0] SEL_RES_LO = 4'h6;
  localparam logic [3:0] SEL_TEMP_HI = 4'hD;
  localparam logic [3:0] SEL_NOP = 4'hE;
  localparam logic [3:0] SEL_TEST = 4'hF;

  localparam logic [3:0] FUNC_DISABLE = 4'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] TEST_USED_MASK = 8'h7E;

  localparam int TEST_TSD_BIT = 6;
  localparam int TEST_POR_BIT = 5;
  localparam int TEST_DISC_TMR_BIT = 4;
  localparam int TEST_DISC_HALT_BIT = 3;
  localparam int TEST_DCDISC_BIT = 2;
  localparam int TEST_ERRDLY_BIT = 1;

  localparam int NUM_PORTS = 4;
  localparam int TMR_W = 27;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ERR_DELAY_MS = 750;
  localparam int DISC_PHASE_MS = 4;
  localparam int DISCONNECT_MIN_MS = 300;
  localparam int ERR_DELAY_CYC = (ERR_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISC_PHASE_CYC = (DISC_PHASE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISCONNECT_CYC =
    (DISCONNECT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic spare_hi;
    logic [3:0] sel;
    logic spare_lo;
    logic [1:0] port;
  } pmrs_ptr_t;

  typedef struct packed {
    logic [3:0] sel;
    logic [1:0] port;
    logic [7:0] data;
  } pmrs_wr_t;

endpackage : pmrs_pkg

// ==== hw/pmrs_timer.sv ====
// module: one-shot down counter with hold and abort, done as a registered pulse
`timescale 1ns/1ps
`default_nettype none
module pmrs_timer (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic hold_in,
  input wire logic [pmrs_pkg::TMR_W-1:0] load_in,
  output logic done_out
);

  typedef struct packed {
    logic active;
    logic [pmrs_pkg::TMR_W-1:0] cnt;
    logic done;
  } pmrs_tmr_st_t;

  pmrs_tmr_st_t st_q;
  pmrs_tmr_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    // abort beats start so a cancelled run never fires late
    if (abort_in) begin
      st_d.active = 1'b0;
    end else if (start_in) begin
      st_d.active = 1'b1;
      st_d.cnt = load_in;
    end else if (st_q.active && !hold_in) begin
      if (st_q.cnt == '0) begin
        st_d.active = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done_out = st_q.done;

endmodule : pmrs_timer
`default_nettype wire

// ==== hw/pmrs_fault_flag.sv ====
// module: sticky fault flag where a set beats a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module pmrs_fault_flag (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);

  typedef struct packed {
    logic flag;
  } pmrs_flag_st_t;

  pmrs_flag_st_t st_q;
  pmrs_flag_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (set_in) begin
      st_d.flag = 1'b1;
    end else if (clear_in) begin
      st_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_out = st_q.flag;

endmodule : pmrs_fault_flag
`default_nettype wire

// ==== tb/pmrs_properties.sv ====
// checker: pointer, read, write and test register timing at the top ports
`timescale 1ns/1ps
`default_nettype none
module pmrs_properties (
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic PTR_WR_IN,
  input wire logic [7:0] PTR_BYTE_IN,
  input wire logic ACK_OUT,
  input wire logic DATA_WR_IN,
  input wire logic [7:0] WR_BYTE_IN,
  input wire logic DATA_RD_IN,
  input wire logic [7:0] RD_BYTE_OUT,
  input wire pmrs_pkg::pmrs_ptr_t PTR_OUT,
  input wire logic [7:0] PORT_RD_BYTE_IN,
  input wire logic PORT_WR_OUT,
  input wire pmrs_pkg::pmrs_wr_t PORT_WR_BUS_OUT,
  input wire logic [3:0] DISABLE_CALL_OUT,
  input wire logic [1:0] CHIP_REV_IN,
  input wire logic [1:0] CHIP_ID_IN,
  input wire logic THERMAL_SHUTDOWN_FORCE_OUT,
  input wire logic DISC_HALT_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  // a pointer in the same cycle wins, so only a lone data write counts
  sequence s_wr;
    DATA_WR_IN && !PTR_WR_IN;
  endsequence
  a_ack_after_ptr: assert property (ACK_OUT == $past(PTR_WR_IN))
    else $error("ack not one cycle after pointer");
  a_ptr_latch_mask: assert property (PTR_WR_IN |=> PTR_OUT == ($past(PTR_BYTE_IN) & 8'h7B))
    else $error("pointer latch wrong");
  a_ptr_holds: assert property (!PTR_WR_IN |=> $stable(PTR_OUT))
    else $error("pointer moved without write");
  a_nop_write_quiet: assert property (s_wr ##0 (PTR_OUT.sel inside {4'h0, 4'hE}) |=> !PORT_WR_OUT)
    else $error("ignored code forwarded");
  a_port_write_fwd: assert property (s_wr ##0 (PTR_OUT.sel inside {[4'h1:4'hD]}) |=>
      PORT_WR_OUT && PORT_WR_BUS_OUT == {$past(PTR_OUT.sel), $past(PTR_OUT.port), $past(WR_BYTE_IN)})
    else $error("port write not forwarded");
  a_test_bits_take: assert property (s_wr ##0 (PTR_OUT.sel == 4'hF) |=>
      THERMAL_SHUTDOWN_FORCE_OUT == $past(WR_BYTE_IN[6]) && DISC_HALT_OUT == $past(WR_BYTE_IN[3]))
    else $error("test bits not taken");
  a_disable_pulse: assert property (s_wr ##0 (PTR_OUT.sel == 4'h2 && WR_BYTE_IN[3:0] == 4'h0) |=>
      DISABLE_CALL_OUT == (4'h1 << $past(PTR_OUT.port)))
    else $error("disable call wrong port");
  a_read_common: assert property (DATA_RD_IN && PTR_OUT.sel == 4'h0 |=>
      RD_BYTE_OUT[3:0] == {$past(CHIP_REV_IN), $past(CHIP_ID_IN)})
    else $error("common read identity wrong");
  a_read_port: assert property (DATA_RD_IN && PTR_OUT.sel inside {[4'h2:4'hD]} |=>
      RD_BYTE_OUT == $past(PORT_RD_BYTE_IN))
    else $error("port read data wrong");
  a_read_zero: assert property (DATA_RD_IN && PTR_OUT.sel inside {4'h1, 4'hE, 4'hF} |=>
      RD_BYTE_OUT == 8'h00)
    else $error("blank code read not zero");
endmodule : pmrs_properties
`default_nettype wire

// ==== tb/pmrs_port_model.sv ====
// partner: per-port result source answering the selected register
`timescale 1ns/1ps
`default_nettype none
module pmrs_port_model (
  input wire pmrs_pkg::pmrs_ptr_t ptr_in,
  output logic [7:0] rd_byte_out
);
  // distinct byte per code and port, so a wrong steer shows up
  assign rd_byte_out = {ptr_in.sel, ptr_in.port, 2'h1};
endmodule : pmrs_port_model
`default_nettype wire

// ==== tb/pmrs_tb_top.sv ====
// testbench: pointer, common status, test register and fault flags
`timescale 1ns/1ps
`default_nettype none
module pmrs_tb_top;
  localparam logic [1:0] REV_STRAP = 2'h2; // arbitrary
  localparam logic [1:0] ID_STRAP = 2'h1; // arbitrary
  logic clk_sys, arst_n, pw, dw, dr, am, ack, thermal_shutdown, por, halt, toff, eoff, pwo;
  logic [7:0] pb, wb, rb, prb, v;
  logic [3:0] fe, lc, dis, ds, dd, dcn;
  pmrs_pkg::pmrs_ptr_t ptr;
  pmrs_pkg::pmrs_wr_t wbus;
  int n_fail = 0;
  int checks_done = 0;
  pmrs_top #(.ERR_DELAY_CYCLES(20), .DISC_PHASE_CYCLES(10), .DISCONNECT_CYCLES(15)) dut (
    .CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n), .PTR_WR_IN(pw), .PTR_BYTE_IN(pb),
    .ACK_OUT(ack), .DATA_WR_IN(dw), .WR_BYTE_IN(wb), .DATA_RD_IN(dr), .RD_BYTE_OUT(rb),
    .PTR_OUT(ptr), .PORT_RD_BYTE_IN(prb), .PORT_WR_OUT(pwo), .PORT_WR_BUS_OUT(wbus),
    .DISABLE_CALL_OUT(dis), .AUTOMATIC_MODE_IN(am), .FAULT_EVENT_IN(fe),
    .CHIP_REV_IN(REV_STRAP), .CHIP_ID_IN(ID_STRAP), .THERMAL_SHUTDOWN_FORCE_OUT(thermal_shutdown),
    .POR_HOLD_OUT(por), .DISC_HALT_OUT(halt), .DISC_TIMERS_OFF_OUT(toff),
    .ERROR_DELAY_TIMER_OFF_OUT(eoff), .DISC_START_IN(ds), .DISC_DONE_OUT(dd),
    .LOW_CURRENT_IN(lc), .DISCONNECT_OUT(dcn)
  );
  pmrs_port_model u_model (.ptr_in(ptr), .rd_byte_out(prb));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ptr_wr(input logic [7:0] b);
    @(negedge clk_sys);
    pw = 1'b1;
    pb = b;
    @(negedge clk_sys);
    pw = 1'b0;
    chk("ack", 8'h01, {7'h00, ack});
  endtask : ptr_wr
  task automatic dat_wr(input logic [7:0] b);
    @(negedge clk_sys);
    dw = 1'b1;
    wb = b;
    @(negedge clk_sys);
    dw = 1'b0;
  endtask : dat_wr
  task automatic dat_rd(output logic [7:0] r);
    @(negedge clk_sys);
    dr = 1'b1;
    @(negedge clk_sys);
    dr = 1'b0;
    r = rb;
  endtask : dat_rd
  // one start pulse on port 0; returns the cycle of its done pulse, zero if none
  task automatic disc_run(output logic [7:0] r);
    @(negedge clk_sys);
    ds = 4'h1;
    @(negedge clk_sys);
    ds = 4'h0;
    r = 8'h00;
    for (int k = 1; k <= 12; k++) begin
      @(negedge clk_sys);
      if (dd[0]) begin
        r = 8'(k);
      end
    end
  endtask : disc_run
  task automatic rd_at(input logic [7:0] p, output logic [7:0] r);
    ptr_wr(p);
    dat_rd(r);
  endtask : rd_at
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    {pw, dw, dr, am} = 4'h0;
    {pb, wb} = 16'h0000;
    {fe, lc, ds} = 12'h000;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    chk("ptr reset", 8'h00, ptr);
    dat_rd(v);
    chk("common reset", {4'h0, REV_STRAP, ID_STRAP}, v);
    $display("reset test done");
    ptr_wr(8'hFF);
    chk("ptr mask", 8'h7B, ptr);
    // test bits only ever set here and always cleared again before other
    dat_wr(8'hFF);
    chk("test outs", 8'h1F, {2'h0, pwo, thermal_shutdown, por, toff, halt, eoff});
    dat_rd(v);
    chk("test read", 8'h00, v);
    disc_run(v);
    chk("disc timers off", 8'h00, v);
    v = 8'h00;
    lc = 4'h2;
    repeat (4) begin
      @(negedge clk_sys);
      v[3:0] = v[3:0] | dcn;
    end
    lc = 4'h0;
    chk("fast disconnect", 8'h02, v);
    dat_wr(8'h00);
    chk("test clear", 8'h00, {3'h0, thermal_shutdown, por, toff, halt, eoff});
    disc_run(v);
    chk("disc phase", 8'h0A, v);
    $display("test register done");
    for (int c = 2; c < 14; c++) begin
      rd_at({1'b0, c[3:0], 3'h3}, v);
      chk("port read", {c[3:0], 4'hD}, v);
    end
    ptr_wr(8'h71);
    dat_wr(8'h55);
    chk("nop write", 8'h00, {7'h00, pwo});
    dat_rd(v);
    chk("nop read", 8'h00, v);
    ptr_wr(8'h1A);
    dat_wr(8'hC3);
    chk("port wr data", 8'hC3, wbus.data);
    chk("port wr addr", 8'h8E, {pwo, 1'b0, wbus.sel, wbus.port});
    $display("select test done");
    @(negedge clk_sys);
    fe = 4'h4;
    @(negedge clk_sys);
    fe = 4'h0;
    repeat (30) @(negedge clk_sys);
    rd_at(8'h02, v);
    chk("pm flag held", {4'h4, REV_STRAP, ID_STRAP}, v);
    ptr_wr(8'h12);
    dat_wr(8'h00);
    chk("disable call", 8'h04, {4'h0, dis});
    rd_at(8'h00, v);
    chk("pm flag clear", {4'h0, REV_STRAP, ID_STRAP}, v);
    am = 1'b1;
    @(negedge clk_sys);
    fe = 4'h1;
    @(negedge clk_sys);
    fe = 4'h0;
    rd_at(8'h03, v);
    chk("auto flag set", {4'h1, REV_STRAP, ID_STRAP}, v);
    repeat (25) @(negedge clk_sys);
    dat_rd(v);
    chk("auto flag clear", {4'h0, REV_STRAP, ID_STRAP}, v);
    $display("fault test done");
    tally_and_finish();
  end
endmodule : pmrs_tb_top
bind pmrs_top pmrs_properties u_props (.*);
`default_nettype wire
